// ===== rtl/adc_seq_regs.svh
// Constants for the converter sequencer: field widths, counts, trigger codes.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define TRIG_SOFTWARE 3'h0
`define TRIG_CLOCKED 3'h7
`define CONV_TAD_COUNT 5'hC
`define BUF_WORDS 16
`define HALF_WORDS 8
`define RESULT_BITS 10
`define SPI_BITS 4
`define ACQUISITION_CLOCK_COUNT_BITS 5
`define DIV_BITS 8
`endif

// ===== rtl/adc_seq_pkg.sv
// Types for the converter sequencer.
// Assumes adc_seq_regs.svh is on the include path.
`include "adc_seq_regs.svh"
package adc_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } seq_state_t;
   // Control bits written by software, grouped.
   typedef struct packed {
      logic on;
      logic [2:0] trig_src;
      logic clk_src_osc;
      logic [`DIV_BITS-1:0] div_sel;
      logic [`ACQUISITION_CLOCK_COUNT_BITS-1:0] acq_count;
      logic [`SPI_BITS-1:0] spi;
      logic split;
      logic offset_cal_enable;
      logic stop_seq;
   } ctrl_t;
endpackage

// ===== rtl/adc_seq.sv
// Conversion sequencer for a successive-approximation converter, with result buffer.
// Assumes all inputs synchronous to CLK; the SAR comparator sits outside and
// returns one decision bit per conversion clock on CMP_BIT.
// How it works
// RULE1 - Auto sample cleared mid sequence: finish conversion, no new acquisition.
// RULE2 - Turning off mid conversion aborts it; buffer word keeps old value.
// RULE3 - Split buffer: half indicator 0 filling words 0-7, 1 filling 8-15.
// RULE4 - Offset calibration forces both sample-hold inputs to analog ground.
// RULE5 - Offset measurement reports only non-negative values.
// RULE6 - Stop-after-sequence: one auto sequence, then clear auto sample, raise flag.
// RULE7 - Stop-after-sequence stays until software clears it; independent of masking.
// RULE8 - Completion bit sets at sequence end; persists in manual mode.
// RULE9 - Auto mode clears completion bit when next acquisition starts.
// RULE10 - Sequence-complete flag latches until software clears it.
// RULE11 - Software trigger: request set starts sampling, clear starts conversion.
// RULE12 - Software spaces request set and clear for enough acquisition time.
// RULE13 - Auto mode re-enters acquisition after conversion, setting request bit.
// RULE14 - Software allows for conversion time between request clears in auto mode.
// RULE15 - Clocked trigger counts programmed conversion clocks then converts.
// RULE16 - Software programs nonzero acquisition count for clocked trigger.
// RULE17 - Each conversion takes twelve conversion clock periods.
// RULE18 - Bus clock divided by divider setting, oscillator undivided.
// RULE19 - Results fill successive buffer words; flag after programmed samples.
`timescale 1ns/100ps
`include "adc_seq_regs.svh"
module adc_seq
   import adc_seq_pkg::*;
#(
   parameter int RW = `RESULT_BITS
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Control
   input wire ctrl_t CTRL,
   input wire logic OSC_TICK,
   input wire logic AUTO_SET,
   input wire logic AUTO_CLR,
   input wire logic SAMPLE_REQUEST_BIT_SET,
   input wire logic SAMPLE_REQUEST_BIT_CLR,
   input wire logic DONE_CLR,
   input wire logic FLAG_CLR,
   // Converter side
   input wire logic CMP_BIT,
   output logic SH_SAMPLE,
   output logic SH_GROUND,
   // Status
   output logic AUTO_SAMPLE_ENABLE,
   output logic SAMPLE_REQUEST_BIT,
   output logic DONE,
   output logic SEQUENCE_COMPLETE_FLAG,
   output logic ACTIVE_HALF_INDICATOR,
   output logic CONVERTING,
   // Result read
   input wire logic [3:0] RD_ADDR,
   output logic [RW-1:0] RD_DATA
);
   seq_state_t st_q, st_d;
   logic [`DIV_BITS:0] div_q;
   logic [`ACQUISITION_CLOCK_COUNT_BITS-1:0] acq_q;
   logic [3:0] bit_q;
   logic [RW-1:0] sar_q;
   logic [3:0] wptr_q;
   logic [`SPI_BITS-1:0] cnt_q;
   logic auto_q, sample_request_bit_q, done_q, flag_q, rd_q;
   logic [RW-1:0] buf_q [`BUF_WORDS];
   logic [RW-1:0] rdat_q;

   function automatic [`DIV_BITS-1:0] ctrl_div(input [`DIV_BITS-1:0] d);
      ctrl_div = d;
   endfunction

   // Wraps at 16, or at 8 within the active half when split
   function automatic [3:0] wptr_next(input [3:0] p, input sp);
      wptr_next = sp ? {p[3], p[2:0] + 3'h1} : p + 4'h1;
   endfunction

   // Conversion clock tick: oscillator used undivided, bus clock divided 2*(N+1)
   wire [`DIV_BITS:0] div_end = {ctrl_div(CTRL.div_sel), 1'b1};
   // At or past the end, so a smaller divider written mid-count cannot stall the tick
   wire tad = CTRL.clk_src_osc ? OSC_TICK : (div_q >= div_end); // [RULE18]
   wire sw_trig = CTRL.trig_src == `TRIG_SOFTWARE;
   wire clk_trig = CTRL.trig_src == `TRIG_CLOCKED;
   wire conv_go_sw = sw_trig && SAMPLE_REQUEST_BIT_CLR && st_q == ST_SAMPLE; // [RULE11]
   wire conv_go_clk = clk_trig && tad && st_q == ST_SAMPLE
                      && acq_q + 5'h1 >= CTRL.acq_count; // [RULE15]
   wire conv_go = conv_go_sw || conv_go_clk;
   // Off on the last tick is an abort, not a completion
   wire conv_end = CTRL.on && st_q == ST_CONVERT && tad
                   && bit_q == 4'(`CONV_TAD_COUNT - 5'h1); // [RULE17]
   wire seq_end = conv_end && cnt_q == CTRL.spi; // [RULE19]
   wire stop_now = seq_end && CTRL.stop_seq; // [RULE6] [RULE7]
   // Next acquisition: manual request or auto sample from idle, or automatic restart after conversion
   wire restart = conv_end && auto_q && !stop_now && !AUTO_CLR; // [RULE1] [RULE13]
   wire acq_start = (st_q == ST_IDLE && (SAMPLE_REQUEST_BIT_SET || auto_q)) || restart;
   wire [3:0] wnext = wptr_next(wptr_q, CTRL.split);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (acq_start) st_d = ST_SAMPLE;
         ST_SAMPLE: if (conv_go) st_d = ST_CONVERT;
         ST_CONVERT: if (conv_end) st_d = restart ? ST_SAMPLE : ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
      if (!CTRL.on) st_d = ST_IDLE; // [RULE2]
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= ST_IDLE;
         div_q <= '0;
         acq_q <= '0;
         bit_q <= '0;
         sar_q <= '0;
      end else begin
         st_q <= st_d;
         div_q <= (tad || CTRL.clk_src_osc) ? '0 : div_q + 9'h1;
         acq_q <= (st_q != ST_SAMPLE) ? '0 : acq_q + {4'h0, tad};
         bit_q <= (st_q != ST_CONVERT) ? '0 : bit_q + {3'h0, tad};
         // Decisions shift in MSB first; last two clocks are settling
         if (st_q == ST_CONVERT && tad && bit_q < 4'(RW))
            sar_q <= {sar_q[RW-2:0], CMP_BIT};
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         auto_q <= 1'b0;
         sample_request_bit_q <= 1'b0;
         done_q <= 1'b0;
         flag_q <= 1'b0;
         wptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (stop_now || AUTO_CLR) auto_q <= 1'b0; // [RULE6]
         else if (AUTO_SET) auto_q <= 1'b1;
         if (acq_start && CTRL.on) sample_request_bit_q <= 1'b1; // [RULE13]
         else if (conv_go || !CTRL.on) sample_request_bit_q <= 1'b0;
         if (seq_end) done_q <= 1'b1; // [RULE8]
         // Auto restart and sequence end share an edge, so clear once sampling is under way
         else if (DONE_CLR || (auto_q && st_q == ST_SAMPLE)) done_q <= 1'b0; // [RULE9]
         if (seq_end) flag_q <= 1'b1; // [RULE10]
         else if (FLAG_CLR) flag_q <= 1'b0;
         if (conv_end) begin
            wptr_q <= seq_end ? {CTRL.split & ~wptr_q[3], 3'h0} : wnext; // [RULE3]
            cnt_q <= seq_end ? '0 : cnt_q + 4'h1;
         end
         if (!CTRL.split && seq_end) wptr_q <= '0;
      end
   end

   // Only completed conversions write; an abort leaves the word untouched
   always_ff @(posedge CLK) begin
      if (conv_end && CTRL.on) // [RULE2] [RULE19]
         buf_q[wptr_q] <= sar_q; // [RULE5]
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) rdat_q <= '0;
      else rdat_q <= buf_q[RD_ADDR];
   end

   assign SH_SAMPLE = st_q == ST_SAMPLE;
   assign SH_GROUND = CTRL.offset_cal_enable; // [RULE4]
   assign AUTO_SAMPLE_ENABLE = auto_q;
   assign SAMPLE_REQUEST_BIT = sample_request_bit_q;
   assign DONE = done_q;
   assign SEQUENCE_COMPLETE_FLAG = flag_q;
   assign ACTIVE_HALF_INDICATOR = CTRL.split & wptr_q[3]; // [RULE3]
   assign CONVERTING = st_q == ST_CONVERT;
   assign RD_DATA = rdat_q;

   property p_abort_idle;
      @(posedge CLK) disable iff (!ARST_N) !CTRL.on |=> st_q == ST_IDLE;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("not idle after off"); // [RULE2]
   property p_flag_sticky;
      @(posedge CLK) disable iff (!ARST_N) flag_q && !FLAG_CLR |=> flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // [RULE10]
   property p_seq_flag;
      @(posedge CLK) disable iff (!ARST_N) seq_end |=> flag_q && done_q;
   endproperty
   a_seq_flag: assert property (p_seq_flag) else $error("flag not set"); // [RULE8]
   property p_stop;
      @(posedge CLK) disable iff (!ARST_N) stop_now |=> !auto_q && st_q == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("auto not cleared"); // [RULE6]
   property p_no_restart;
      @(posedge CLK) disable iff (!ARST_N) conv_end && !auto_q |=> st_q == ST_IDLE;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("restarted"); // [RULE1]
   property p_half;
      @(posedge CLK) disable iff (!ARST_N)
         CTRL.split && seq_end |=> ACTIVE_HALF_INDICATOR != $past(ACTIVE_HALF_INDICATOR);
   endproperty
   a_half: assert property (p_half) else $error("half wrong"); // [RULE3]
   property p_sw_conv;
      @(posedge CLK) disable iff (!ARST_N) conv_go_sw && CTRL.on |=> st_q == ST_CONVERT;
   endproperty
   a_sw_conv: assert property (p_sw_conv) else $error("no conversion"); // [RULE11]
   property p_ground;
      @(posedge CLK) disable iff (!ARST_N) CTRL.offset_cal_enable |-> SH_GROUND;
   endproperty
   a_ground: assert property (p_ground) else $error("not grounded"); // [RULE4]
   property p_restart;
      @(posedge CLK) disable iff (!ARST_N) restart && CTRL.on |=> sample_request_bit_q && SH_SAMPLE;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart"); // [RULE13]
   property p_done_auto;
      @(posedge CLK) disable iff (!ARST_N) auto_q && st_q == ST_SAMPLE |=> !done_q;
   endproperty
   a_done_auto: assert property (p_done_auto) else $error("done kept in auto"); // [RULE9]
   property p_clk_hold;
      @(posedge CLK) disable iff (!ARST_N)
         clk_trig && CTRL.on && st_q == ST_SAMPLE && acq_q + 5'h1 < CTRL.acq_count |=> SH_SAMPLE;
   endproperty
   a_clk_hold: assert property (p_clk_hold) else $error("early conversion"); // [RULE15]
   c_seq: cover property (@(posedge CLK) seq_end);
   c_stop: cover property (@(posedge CLK) stop_now);
   c_clk: cover property (@(posedge CLK) conv_go_clk);
   c_restart: cover property (@(posedge CLK) restart);
   c_abort: cover property (@(posedge CLK) st_q == ST_CONVERT && !CTRL.on);
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the converter sequencer: random comparator bits and counts.
// Assumes adc_seq_pkg compiled first; oscillator stand-in ticks every third CLK.
`timescale 1ns/100ps
module testbench;
   import adc_seq_pkg::*;
   logic CLK = 0;
   logic ARST_N = 0;
   logic OSC_TICK = 0;
   logic CMP_BIT = 0;
   logic wb;
   ctrl_t c = '0;
   logic [5:0] pl = '0;
   logic [3:0] RD_ADDR = '0;
   logic SH_SAMPLE, SH_GROUND, AUTO_SAMPLE_ENABLE, SAMPLE_REQUEST_BIT, DONE, FLAG, HALF, CONV;
   logic [9:0] RD_DATA;
   logic [3:0] st;
   logic [31:0] s = 32'hC0799EE7;
   logic [31:0] r;
   int failures = 0;
   int cmp_count = 0;
   int n;
   int m;
   logic [1:0] oc = '0;
   assign st = {CONV, SH_SAMPLE, DONE, FLAG};
   always #4 CLK = ~CLK;
   adc_seq dut (.CLK(CLK), .ARST_N(ARST_N), .CTRL(c), .OSC_TICK(OSC_TICK),
      .AUTO_SET(pl[0]), .AUTO_CLR(pl[1]), .SAMPLE_REQUEST_BIT_SET(pl[2]), .SAMPLE_REQUEST_BIT_CLR(pl[3]),
      .DONE_CLR(pl[4]), .FLAG_CLR(pl[5]), .CMP_BIT(CMP_BIT), .SH_SAMPLE(SH_SAMPLE),
      .SH_GROUND(SH_GROUND), .AUTO_SAMPLE_ENABLE(AUTO_SAMPLE_ENABLE),
      .SAMPLE_REQUEST_BIT(SAMPLE_REQUEST_BIT), .DONE(DONE), .SEQUENCE_COMPLETE_FLAG(FLAG),
      .ACTIVE_HALF_INDICATOR(HALF), .CONVERTING(CONV), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA));
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [9:0] res(input logic b);
      return {10{b}};
   endfunction
   // Conversion clock period in CLK cycles
   function automatic int tad_len(input logic osc, input logic [7:0] d);
      return osc ? 3 : 2 * (d + 1);
   endfunction
   task automatic tick(input int k = 1);
      repeat (k) @(posedge CLK);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic pulse(input int i);
      pl[i] = 1'b1;
      tick();
      pl[i] = 1'b0;
   endtask
   // Bounded wait; n keeps the cycles spent for duration checks
   task automatic wait_sig(input int i);
      n = 0;
      while (st[i] !== 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      chk("wait", n < 3000, 1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [9:0] e);
      RD_ADDR = a;
      tick(2);
      chk("rd_data", RD_DATA, e);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Oscillator stand-in, ignored while the bus clock is selected
   always @(posedge CLK) begin
      #1;
      oc = (oc == 2'h2) ? 2'h0 : oc + 2'h1;
      OSC_TICK = oc == 2'h2;
   end
   initial begin
      #400000;
      failures++;
      give_verdict();
   end
   initial begin
      tick(5);
      ARST_N = 1'b1;
      chk("reset", {DONE, FLAG, SAMPLE_REQUEST_BIT, CONV, AUTO_SAMPLE_ENABLE}, 0);
      c.on = 1'b1;
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         CMP_BIT = r[0];
         pulse(4);
         pulse(5);
         pulse(2);
         chk("sample_request_bit", {SH_SAMPLE, SAMPLE_REQUEST_BIT}, 2'b11);
         tick(r[7:4] + 2);
         pulse(3);
         chk("conv", CONV, 1);
         wait_sig(1);
         chk("conv_len", n >= 22 && n <= 26, 1);
         tick(10);
         chk("done_flag", {DONE, FLAG}, 2'b11);
         rd(0, res(CMP_BIT));
      end
      for (int k = 0; k < 2; k++) begin
         r = rnd();
         c.clk_src_osc = k[0];
         c.div_sel = {6'h00, r[1:0]};
         m = tad_len(k[0], c.div_sel);
         pulse(4);
         pulse(2);
         tick(2);
         pulse(3);
         wait_sig(1);
         chk("tad_len", n > 11 * m && n <= 12 * m, 1);
      end
      c.clk_src_osc = 1'b0;
      c.div_sel = '0;
      wb = CMP_BIT;
      CMP_BIT = ~wb;
      pulse(2);
      tick(3);
      pulse(3);
      tick(8);
      c.on = 1'b0;
      tick(3);
      c.on = 1'b1;
      chk("abort", CONV, 0);
      rd(0, res(wb));
      c.offset_cal_enable = 1'b1;
      tick();
      chk("ground", SH_GROUND, 1);
      c.offset_cal_enable = 1'b0;
      tick();
      chk("ground_off", SH_GROUND, 0);
      c.trig_src = 3'h7;
      r = rnd();
      c.acq_count = r[4:0] | 5'h01;
      pulse(4);
      pulse(2);
      wait_sig(3);
      chk("acq_len", n >= 2 * c.acq_count - 2 && n <= 2 * c.acq_count + 2, 1);
      wait_sig(1);
      c.acq_count = 5'h02;
      c.stop_seq = 1'b1;
      c.spi = {2'h0, r[6:5]} + 4'h1;
      for (int b = 0; b < 2; b++) begin
         CMP_BIT = b[0];
         pulse(5);
         pulse(0);
         wait_sig(0);
         tick(40);
         chk("stop_seq", {AUTO_SAMPLE_ENABLE, SH_SAMPLE, FLAG}, 3'b001);
         for (int k = 0; k <= c.spi; k++) rd(k[3:0], res(b[0]));
      end
      c.stop_seq = 1'b0;
      c.spi = 4'h0;
      c.acq_count = 5'h04;
      pulse(0);
      wait_sig(3);
      wait_sig(1);
      chk("reacq", {SH_SAMPLE, SAMPLE_REQUEST_BIT, CONV}, 3'b110);
      tick(2);
      chk("done_auto", DONE, 0);
      // New comparator level makes the last write visible
      CMP_BIT = 1'b0;
      pulse(1);
      wait_sig(1);
      tick(40);
      chk("auto_stop", {SH_SAMPLE, CONV}, 2'b00);
      rd(4'h0, res(1'b0));
      c.trig_src = 3'h0;
      pulse(0);
      for (int k = 0; k < 2; k++) begin
         r = rnd();
         CMP_BIT = r[0];
         tick(r[7:4] + 3);
         chk("auto_sw", {SH_SAMPLE, SAMPLE_REQUEST_BIT, DONE}, 3'b110);
         pulse(3);
         wait_sig(1);
         rd(4'h0, res(r[0]));
      end
      pulse(1);
      pulse(3);
      chk("auto_sw_conv", CONV, 1);
      tick(30);
      chk("auto_sw_stop", {SH_SAMPLE, CONV, AUTO_SAMPLE_ENABLE}, 3'b000);
      c.trig_src = 3'h7;
      c.split = 1'b1;
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         CMP_BIT = r[0];
         chk("half", HALF, k[0]);
         pulse(4);
         pulse(2);
         wait_sig(1);
         rd(k[0] ? 4'h8 : 4'h0, res(CMP_BIT));
      end
      give_verdict();
   end
endmodule
